// ==== logic/serial_bus_module_regs.vh ====
// Register offsets, field positions and reset values of the serial bus module
// Assumes an 8-bit register port with one-cycle read latency
`ifndef SERIAL_BUS_MODULE_REGS_VH
`define SERIAL_BUS_MODULE_REGS_VH
// Offsets
`define SBM_CTRL_ADDR 4'h0
`define SBM_STATUS_ADDR 4'h1
`define SBM_CMD_ADDR 4'h2
`define SBM_DATA_ADDR 4'h3
`define SBM_ADDR_ADDR 4'h4
`define SBM_BUS_ADDR 4'h5
`define SBM_IRQ_ADDR 4'h6
`define SBM_MASK_ADDR 4'h7
// Control fields
`define SBM_CTRL_EN 0
`define SBM_CTRL_TOUT_EN 1
// Status fields
`define SBM_ST_DIF 7
`define SBM_ST_STOP_ADDRESS_FLAG 6
`define SBM_ST_HOLD 5
`define SBM_ST_COLL 3
`define SBM_ST_DIR 1
`define SBM_ST_AP 0
// Bus state field values
`define SBM_BUS_IDLE 2'h1
`define SBM_BUS_BUSY 2'h3
// Slave response command
`define SBM_CMD_RESPONSE 2'h3
// Interrupt event bits
`define SBM_EV_ADDR 0
`define SBM_EV_DATA 1
`define SBM_EV_STOP 2
`define SBM_EV_TOUT 3
`define SBM_EV_DROP 4
// Reset values
`define SBM_CTRL_RST 8'h00
`define SBM_ADDR_RST 8'h00
// Timing
`define SBM_CLK_HZ 50000000
`define SBM_TOUT_US 50
`define SBM_TOUT_CYC ((`SBM_CLK_HZ / 1000000) * `SBM_TOUT_US)
`endif

// ==== logic/serial_bus_module.v ====
// Two-wire slave: flag handling, clock hold, timeout, register port
// Assumes SCL/SDA open-drain pins resolved outside; registers on one clock
// Behaviour
// - START clears collision flag; repeated START does not
// - Clear racing stop/address set leaves flag set; SCL held only when the set is an address match
// - Timeout coinciding with START drops transaction
// - Response command clears data flag one cycle later
`timescale 1ns/100ps
`default_nettype none
`include "serial_bus_module_regs.vh"
module serial_bus_module #(
  parameter TOUT_CYC = `SBM_TOUT_CYC
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire i_clk_en,
  // Register port
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // Two-wire pins
  input wire i_scl,
  output wire o_scl,
  output wire o_scl_oe,
  input wire i_sda,
  output wire o_sda,
  output wire o_sda_oe,
  // Interrupt
  output wire o_irq
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_ADDR = 4'b0010;
  localparam ST_ACK = 4'b0100;
  localparam ST_DATA = 4'b1000;
  reg [1:0] scl_sync_reg, sda_sync_reg;
  reg scl_d_reg, sda_d_reg;
  reg [7:0] ctrl_reg, own_addr_reg, shift_reg, data_reg, mask_reg;
  reg [4:0] irq_reg;
  reg [3:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg dif_reg, stop_address_flag_reg, hold_reg, coll_reg, dir_reg, ap_reg, busy_reg;
  reg dif_clr_reg, ack_drive_reg, tx_drive_reg;
  reg [31:0] tout_cnt_reg;
  wire scl = scl_sync_reg[1];
  wire sda = sda_sync_reg[1];
  wire scl_rise = scl & ~scl_d_reg;
  wire scl_fall = ~scl & scl_d_reg;
  wire start_det = scl & scl_d_reg & ~sda & sda_d_reg;
  wire stop_det = scl & scl_d_reg & sda & ~sda_d_reg;
  wire en = ctrl_reg[`SBM_CTRL_EN];
  wire tout_en = ctrl_reg[`SBM_CTRL_TOUT_EN];
  wire tout_hit = tout_en & busy_reg & (tout_cnt_reg == TOUT_CYC - 1);
  wire wr_st = i_wr & (i_addr == `SBM_STATUS_ADDR);
  wire wr_cmd = i_wr & (i_addr == `SBM_CMD_ADDR);
  wire resp_cmd = wr_cmd & (i_wdata[1:0] == `SBM_CMD_RESPONSE);
  wire rd_irq = i_rd & (i_addr == `SBM_IRQ_ADDR);
  wire addr_match = (state_reg == ST_ADDR) & scl_rise & (bit_cnt_reg == 4'h7) &
    (shift_reg[6:0] == own_addr_reg[6:0]);
  wire data_done = (state_reg == ST_DATA) & scl_rise & (bit_cnt_reg == 4'h7);
  wire stop_address_flag_set = addr_match | (stop_det & en);
  wire stop_address_flag_clr = wr_st & i_wdata[`SBM_ST_STOP_ADDRESS_FLAG];
  wire [4:0] ev = {tout_hit & start_det, tout_hit, stop_det & en, data_done, addr_match};
  wire [7:0] status = {dif_reg, stop_address_flag_reg, hold_reg, 1'b0, coll_reg, 1'b0, dir_reg, ap_reg};
  wire [1:0] bus_state = busy_reg ? `SBM_BUS_BUSY : `SBM_BUS_IDLE;
  assign o_scl = 1'b0;
  assign o_scl_oe = hold_reg;
  assign o_sda = 1'b0;
  assign o_sda_oe = ack_drive_reg | tx_drive_reg;
  assign o_irq = |(irq_reg & mask_reg[4:0]);
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      ctrl_reg <= `SBM_CTRL_RST;
      own_addr_reg <= `SBM_ADDR_RST;
      shift_reg <= 8'h00;
      data_reg <= 8'h00;
      mask_reg <= 8'h00;
      irq_reg <= 5'h00;
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      dif_reg <= 1'b0;
      stop_address_flag_reg <= 1'b0;
      hold_reg <= 1'b0;
      coll_reg <= 1'b0;
      dir_reg <= 1'b0;
      ap_reg <= 1'b0;
      busy_reg <= 1'b0;
      dif_clr_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
      tx_drive_reg <= 1'b0;
      tout_cnt_reg <= 32'h0000_0000;
      o_rdata <= 8'h00;
    end else if (i_clk_en) begin
      scl_sync_reg <= {scl_sync_reg[0], i_scl};
      sda_sync_reg <= {sda_sync_reg[0], i_sda};
      scl_d_reg <= scl;
      sda_d_reg <= sda;
      // Register reads
      o_rdata <= 8'h00;
      if (i_rd) begin
        case (i_addr)
          `SBM_CTRL_ADDR: o_rdata <= ctrl_reg;
          `SBM_STATUS_ADDR: o_rdata <= status;
          `SBM_DATA_ADDR: o_rdata <= data_reg;
          `SBM_ADDR_ADDR: o_rdata <= own_addr_reg;
          `SBM_BUS_ADDR: o_rdata <= {6'h00, bus_state};
          `SBM_IRQ_ADDR: o_rdata <= {3'h0, irq_reg};
          `SBM_MASK_ADDR: o_rdata <= mask_reg;
          default: o_rdata <= 8'h00;
        endcase
      end
      if (i_wr) begin
        case (i_addr)
          `SBM_CTRL_ADDR: ctrl_reg <= i_wdata;
          `SBM_DATA_ADDR: data_reg <= i_wdata;
          `SBM_ADDR_ADDR: own_addr_reg <= i_wdata;
          `SBM_MASK_ADDR: mask_reg <= i_wdata;
          default: ;
        endcase
      end
      // Sticky events; set wins over read clear
      irq_reg <= (rd_irq ? 5'h00 : irq_reg) | ev;
      // Bus busy tracking and timeout
      if (start_det)
        busy_reg <= 1'b1;
      else if (stop_det | tout_hit)
        busy_reg <= 1'b0;
      if (!busy_reg | start_det | ~scl | ~sda)
        tout_cnt_reg <= 32'h0000_0000;
      else
        tout_cnt_reg <= tout_cnt_reg + 32'h0000_0001;
      // Collision flag
      if (start_det & ~busy_reg)
        coll_reg <= 1'b0;
      else if (wr_st & i_wdata[`SBM_ST_COLL])
        coll_reg <= 1'b0;
      else if (tx_drive_reg & scl_rise & sda & ~shift_reg[7])
        coll_reg <= 1'b1;
      // Stop/address flag and clock hold
      if (stop_address_flag_set) begin
        stop_address_flag_reg <= 1'b1;
        ap_reg <= addr_match;
        if (addr_match & ~stop_address_flag_clr)
          hold_reg <= 1'b1;
        else if (addr_match)
          hold_reg <= 1'b1;
      end else if (stop_address_flag_clr) begin
        stop_address_flag_reg <= 1'b0;
        hold_reg <= dif_reg;
      end
      // Data flag; response command clears it a cycle later
      dif_clr_reg <= wr_cmd & (i_wdata[1:0] == `SBM_CMD_RESPONSE);
      if (data_done) begin
        dif_reg <= 1'b1;
        hold_reg <= 1'b1;
        if (!dir_reg)
          data_reg <= {shift_reg[6:0], sda};
      end else if (dif_clr_reg) begin
        dif_reg <= 1'b0;
        hold_reg <= stop_address_flag_reg & ap_reg;
        if (dir_reg)
          shift_reg <= data_reg;
      end
      if (wr_cmd & (i_wdata[1:0] == `SBM_CMD_RESPONSE) & stop_address_flag_reg & ap_reg) begin
        stop_address_flag_reg <= 1'b0;
        hold_reg <= 1'b0;
        if (dir_reg)
          shift_reg <= data_reg;
      end
      // Slave receive/transmit sequencer
      if (!en | stop_det | tout_hit) begin
        state_reg <= ST_IDLE;
        ack_drive_reg <= 1'b0;
        tx_drive_reg <= 1'b0;
      end else if (start_det) begin
        state_reg <= tout_hit ? ST_IDLE : ST_ADDR;
        bit_cnt_reg <= 4'h0;
      end else begin
        case (state_reg)
          ST_IDLE: ;
          ST_ADDR: if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h7) begin
              dir_reg <= sda;
              state_reg <= addr_match ? ST_ACK : ST_IDLE;
            end
          end
          ST_ACK: begin
            // Acknowledge set up on the edge that lets the held clock go after the address, one cycle before that after data
            if (resp_cmd & hold_reg)
              ack_drive_reg <= 1'b1;
            else if (scl_fall & ack_drive_reg) begin
              ack_drive_reg <= 1'b0;
              state_reg <= ST_DATA;
              bit_cnt_reg <= 4'h0;
              tx_drive_reg <= dir_reg & ~data_reg[7];
            end
          end
          ST_DATA: begin
            if (scl_rise) begin
              if (!dir_reg)
                shift_reg <= {shift_reg[6:0], sda};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            if (scl_fall & dir_reg & (bit_cnt_reg != 4'h8)) begin
              shift_reg <= {shift_reg[6:0], 1'b1};
              tx_drive_reg <= ~shift_reg[6];
            end
            if (data_done)
              state_reg <= ST_ACK;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // serial_bus_module
`default_nettype wire

// ==== verification/serial_bus_module_asserts.sv ====
// Port checker for the serial bus module
// Assumes it is bound onto serial_bus_module
`timescale 1ns/100ps
`default_nettype none
`include "serial_bus_module_regs.vh"
module serial_bus_module_asserts (
  // Watched ports
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire o_scl_oe,
  input wire o_irq
);
  wire resp = i_wr && i_addr == `SBM_CMD_ADDR && i_wdata[1:0] == `SBM_CMD_RESPONSE;
  wire st_rd = i_rd && i_addr == `SBM_STATUS_ADDR;
  wire st_clr = i_wr && i_addr == `SBM_STATUS_ADDR && i_wdata[`SBM_ST_STOP_ADDRESS_FLAG];
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  hold_release_a: assert property (resp |-> ##[1:2] !o_scl_oe)
    else $error("clock hold kept after response");
  dif_late_a: assert property (resp ##2 st_rd |=> !o_rdata[`SBM_ST_DIF])
    else $error("data flag still set");
  flag_clear_a: assert property (st_clr ##2 st_rd |=> !o_rdata[`SBM_ST_STOP_ADDRESS_FLAG])
    else $error("stop flag not cleared");
  hold_status_a: assert property (st_rd |=> o_rdata[`SBM_ST_HOLD] == $past(o_scl_oe))
    else $error("hold status differs from pin drive");
  unmapped_a: assert property (i_rd && i_addr[3] |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  cover property (resp && o_scl_oe);
  cover property ($rose(o_irq));
  cover property (resp ##2 st_rd);
endmodule // serial_bus_module_asserts
bind serial_bus_module serial_bus_module_asserts i_serial_bus_module_asserts (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_scl_oe(o_scl_oe),
  .o_irq(o_irq));
`default_nettype wire

// ==== verification/bus_master_model.sv ====
// Two-wire bus master driving open-drain pull-downs
// Assumes pull-ups resolved in the bench; 160 ns bit clock
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
  // Resolved bus levels
  input wire logic i_scl,
  input wire logic i_sda,
  // Pull-down requests
  output var logic o_scl_low = 1'b0,
  output var logic o_sda_low = 1'b0
);
  task automatic start;
    #80 o_sda_low = 1'b1;
    #80 o_scl_low = 1'b1;
  endtask
  task automatic stop;
    #80 o_sda_low = 1'b1;
    #80 o_scl_low = 1'b0;
    #80 o_sda_low = 1'b0;
  endtask
  // Eight data bits then the acknowledge slot, honouring clock stretch
  task automatic send_byte(input logic [7:0] b, output logic ack);
    int i;
    int n;
    for (i = 0; i < 9; i++) begin
      #40 o_sda_low = (i < 8) && !b[7];
      b = b << 1;
      #40 o_scl_low = 1'b0;
      for (n = 0; n < 5000 && !i_scl; n++)
        #20;
      ack = !i_sda;
      #80 o_scl_low = 1'b1;
    end
  endtask
endmodule // bus_master_model
`default_nettype wire

// ==== verification/tb.sv ====
// Bench for the serial bus module flags and clock hold
// Assumes bus_master_model on the pins; 50 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "serial_bus_module_regs.vh"
module tb;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] rd_val;
  logic ack;
  wire [7:0] o_rdata;
  wire o_scl_oe, o_sda_oe, o_irq, m_scl_low, m_sda_low;
  wire scl = !(m_scl_low || o_scl_oe);
  wire sda = !(m_sda_low || o_sda_oe);
  int fail_count = 0;
  int samples_checked = 0;
  always #10 i_ref_clk = !i_ref_clk;
  serial_bus_module #(.TOUT_CYC(20)) i_serial_bus_module (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .i_clk_en(1'b1), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(scl), .o_scl(), .o_scl_oe(o_scl_oe),
    .i_sda(sda), .o_sda(), .o_sda_oe(o_sda_oe), .o_irq(o_irq));
  bus_master_model i_bus_master_model (.i_scl(scl), .i_sda(sda), .o_scl_low(m_scl_low),
    .o_sda_low(m_sda_low));
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 rd_val = o_rdata;
  endtask
  task automatic wait_hold;
    int n;
    for (n = 0; n < 3000 && o_scl_oe !== 1'b1; n++)
      @(posedge i_ref_clk);
    if (n == 3000) begin
      fail_count++;
      end_of_test;
    end
  endtask
  task automatic t_setup;
    rd(`SBM_CTRL_ADDR);
    check("control reset", rd_val, `SBM_CTRL_RST);
    rd(4'hf);
    check("unmapped", rd_val, 8'h00);
    wr(`SBM_CTRL_ADDR, 8'h01);
    wr(`SBM_ADDR_ADDR, 8'hff);
    wr(`SBM_MASK_ADDR, 8'h00);
  endtask
  task automatic t_address;
    fork
      begin
        i_bus_master_model.start;
        i_bus_master_model.send_byte(8'hfe, ack);
      end
      begin
        wait_hold;
        rd(`SBM_STATUS_ADDR);
        check("address status", rd_val & 8'he0, 8'h60);
        check("irq masked", 8'(o_irq), 8'h00);
        wr(`SBM_MASK_ADDR, 8'h01);
        @(posedge i_ref_clk);
        #1 check("irq raised", 8'(o_irq), 8'h01);
        rd(`SBM_IRQ_ADDR);
        check("irq events", rd_val & 8'h1f, 8'h01);
        @(posedge i_ref_clk);
        #1 check("irq cleared", 8'(o_irq), 8'h00);
        check("scl held low", 8'(scl), 8'h00);
        wr(`SBM_STATUS_ADDR, 8'h08);
        wr(`SBM_CMD_ADDR, 8'h03);
      end
    join
    check("address ack", 8'(ack), 8'h01);
  endtask
  task automatic t_data;
    fork
      i_bus_master_model.send_byte(8'h5a, ack);
      begin
        wait_hold;
        rd(`SBM_STATUS_ADDR);
        check("data status", rd_val & 8'he0, 8'ha0);
        @(posedge i_ref_clk);
        i_addr <= `SBM_CMD_ADDR;
        i_wdata <= 8'h03;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        i_addr <= `SBM_STATUS_ADDR;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        #1 check("flag next", o_rdata & 8'h80, 8'h80);
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 check("flag later", o_rdata & 8'h80, 8'h00);
      end
    join
    check("data ack", 8'(ack), 8'h01);
  endtask
  task automatic t_stop;
    i_bus_master_model.stop;
    repeat (8) @(posedge i_ref_clk);
    rd(`SBM_BUS_ADDR);
    check("bus state", rd_val & 8'h03, {6'h00, `SBM_BUS_IDLE});
    wr(`SBM_STATUS_ADDR, 8'h00);
    rd(`SBM_STATUS_ADDR);
    check("stop kept", rd_val & 8'he0, 8'h40);
    wr(`SBM_STATUS_ADDR, 8'h40);
    rd(`SBM_STATUS_ADDR);
    check("stop cleared", rd_val & 8'he0, 8'h00);
  endtask
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    t_setup;
    t_address;
    t_data;
    t_stop;
    end_of_test;
  end
endmodule // tb
`default_nettype wire
